// *** logic/reset_sequencer.sv ***
// reset synchroniser and power-on sequencer of the controller core
// What this block and the external party must do
// R01 - External party holds reset low at least two machine cycles, twenty-four periods.
// R02 - Internal reset runs from second low machine cycle, repeated each cycle.
// R03 - Address-latch and program-store strobes become inputs during reset.
// R04 - External party must not drive those strobes during reset.
// R05 - Execution starts at address zero after a correct reset.
// R06 - Boot-select pin level at reset chooses normal or bootstrap mode.
// R07 - Ports 0 to 6 latches set to FF; port 0 floats.
// R08 - Ports 7 and 8 always read the live pin levels.
// R09 - Reset never alters internal data RAM.
// R10 - Reset input sampled once per machine cycle, at state 5 phase 2.
// R11 - Two machine cycles load register defaults and port latches.
// R12 - Auxiliary watchdog clock lets reset complete without main oscillator.
// R13 - Release seen at S5P2; address at next S5P1; strobe falls at S5P2.
// R14 - Release to first strobe fall is one to under two machine cycles.
// R15 - Watchdog flags failure while its rc oscillator outruns the main one.
// R16 - During failure the device is clocked from the rc oscillator.
// R17 - After recovery, hold reset 768 rc cycles, then switch clock back.
// R18 - A still-asserted external reset keeps the device from executing.
// R19 - External reset ends hardware power-down and overrides its input.
// R20 - External reset ends software power-down.
// R21 - External reset clears the oscillator-failure status flag.
// R22 - External party holds reset through oscillator start and watchdog phase.
// R23 - Reset output mirrors the combined reset; internal sources last two cycles.
// R24 - Phases, states and machine cycles come from the oscillator clock.
// R25 - A machine cycle has six states of two phases each.
`timescale 1ns/1ps
`include "reset_seq_defs.svh"
module reset_sequencer (
   // clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     nrst,
   // oscillator ticks, one per oscillator period
   input  wire logic                     oscTick,
   input  wire logic                     rcTick,
   // pins
   input  wire logic                     resetInN,
   input  wire logic                     boot_select_pin,
   input  wire logic                     hw_powerdown_input,
   input  wire logic [7:0]               port7Pins,
   input  wire logic [7:0]               port8Pins,
   // core requests
   input  wire logic                     wdtRstReq,
   input  wire logic                     swPowerdownReq,
   input  wire logic                     portWr,
   input  wire logic [2:0]               portWrIdx,
   input  wire logic [7:0]               portWrData,
   // strobes and first fetch
   output reset_seq_pkg::strobe_t        strobe_q,
   output reset_seq_pkg::fetch_t         fetch_q,
   // ports
   output logic [6:0][7:0]               portLatch_q,
   output logic [7:0]                    port0Oe_q,
   output logic [7:0]                    port7Read_q,
   output logic [7:0]                    port8Read_q,
   // status
   output logic                          reset_out_n,
   output logic                          bootstrapMode_q,
   output logic                          sfrLoad_q,
   output logic                          cpuRun_q,
   output logic                          swPowerDown_q,
   output logic                          hwPowerDown_q,
   output logic                          osc_fail_status_flag,
   output logic                          clkFromRc
);
   import reset_seq_pkg::*;

   seq_t       seq_q;
   seq_t       seq_d;
   logic [3:0] phase_q;
   logic [1:0] lowCnt_q;
   logic [1:0] rstMc_q;
   logic [1:0] intMc_q;
   logic       tick;
   logic       mcEnd;
   logic       atS5P2;
   logic       extRst;
   logic       owdRst;
   logic       useRc;
   logic       rstAll;

   function automatic logic at_phase(input logic t, input logic [3:0] p,
                                     input logic [3:0] want);
      return t && (p == want);
   endfunction

   function automatic logic [1:0] sat_inc(input logic [1:0] v, input logic [1:0] top);
      return (v == top) ? v : v + 2'h1;
   endfunction

   osc_watchdog owd (
      .clk_sys      (clk_sys),
      .nrst         (nrst),
      .oscTick      (oscTick),
      .rcTick       (rcTick),
      .extRstActive (extRst),
      .useRc_q      (useRc),
      .owdRstReq_q  (owdRst),
      .owdStatus_q  (osc_fail_status_flag)
   );

   // the rc oscillator drives the timing while the main one is failed
   assign tick   = useRc ? rcTick : oscTick;  // [R12] [R16]
   assign mcEnd  = at_phase(tick, phase_q, `PH_LAST);
   assign atS5P2 = at_phase(tick, phase_q, `PH_S5P2);
   assign extRst = lowCnt_q == `LOW_MC_ACT;  // [R02]
   assign rstAll = extRst || owdRst || wdtRstReq || (intMc_q != 2'h0);  // [R23]

   // twelve phases: state n phase m sits at index 2*(n-1)+(m-1)
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         phase_q <= 4'h0;
      end else if (tick) begin
         phase_q <= mcEnd ? 4'h0 : phase_q + 4'h1;  // [R24] [R25]
      end
   end

   // pin sampled once per machine cycle; a high sample ends external reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         lowCnt_q <= 2'h0;
      end else if (atS5P2) begin
         lowCnt_q <= resetInN ? 2'h0 : sat_inc(lowCnt_q, `LOW_MC_ACT);  // [R10] [R02]
      end
   end

   // internal sources stretched to the least reset length; one extra count
   // covers the partial machine cycle in which the request arrives
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         intMc_q <= 2'h0;
      end else if (owdRst || wdtRstReq) begin
         intMc_q <= `RST_MIN_MC + 2'h1;  // [R23]
      end else if (mcEnd && intMc_q != 2'h0) begin
         intMc_q <= intMc_q - 2'h1;
      end
   end

   // machine cycles spent in reset; the first count is a partial cycle, so
   // defaults are loaded after two complete ones
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstMc_q   <= 2'h0;
         sfrLoad_q <= 1'b0;
      end else begin
         if (!rstAll) begin
            rstMc_q <= 2'h0;
         end else if (mcEnd) begin
            rstMc_q <= sat_inc(rstMc_q, `RST_MIN_MC + 2'h1);  // [R11]
         end
         sfrLoad_q <= rstAll && rstMc_q == (`RST_MIN_MC + 2'h1);  // [R11]
      end
   end

   // sequence: reset, wait for S5P1 after release, strobe, run
   always_comb begin
      seq_d = seq_q;
      case (seq_q)
         ST_RUN: begin
            if (rstAll) begin
               seq_d = ST_RESET;
            end
         end
         ST_RESET: begin
            if (!rstAll && rstMc_q == (`RST_MIN_MC + 2'h1)) begin
               seq_d = ST_WAIT;  // [R18] [R13]
            end
         end
         ST_WAIT: begin
            if (rstAll) begin
               seq_d = ST_RESET;
            end else if (at_phase(tick, phase_q, `PH_S5P1)) begin
               seq_d = ST_ALE;  // [R13]
            end
         end
         ST_ALE: begin
            if (rstAll) begin
               seq_d = ST_RESET;
            end else if (atS5P2) begin
               seq_d = ST_RUN;  // [R13] [R14]
            end
         end
         default: seq_d = ST_RESET;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         seq_q <= ST_RESET;
      end else begin
         seq_q <= seq_d;
      end
   end

   // strobes float as inputs in reset; first fetch of address zero
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         strobe_q <= '0;
         fetch_q  <= '0;
      end else begin
         strobe_q.aleOe       <= seq_d != ST_RESET;  // [R03]
         strobe_q.progStoreOe <= seq_d != ST_RESET;  // [R03]
         strobe_q.progStoreOut <= 1'b1;
         if (seq_d == ST_RESET) begin
            strobe_q.aleOut <= 1'b0;
            fetch_q.valid   <= 1'b0;
         end else if (seq_q == ST_WAIT && seq_d == ST_ALE) begin
            strobe_q.aleOut <= 1'b1;
            fetch_q.valid   <= 1'b1;
            fetch_q.addr    <= `BOOT_ADDR;  // [R05]
            fetch_q.extMem  <= !bootstrapMode_q;  // [R06]
         end else if (seq_q == ST_ALE && seq_d == ST_RUN) begin
            strobe_q.aleOut <= 1'b0;  // [R13]
         end
      end
   end

   // boot mode taken from the pin while reset holds
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bootstrapMode_q <= 1'b0;
      end else if (seq_q == ST_RESET) begin
         bootstrapMode_q <= boot_select_pin;  // [R06]
      end
   end

   // port latches forced to ones during reset; data RAM is never touched here
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         portLatch_q <= {7{`PORT_RST_VAL}};
         port0Oe_q   <= 8'h00;
      end else if (rstAll) begin
         portLatch_q <= {7{`PORT_RST_VAL}};  // [R07] [R11] [R09]
         port0Oe_q   <= 8'h00;  // [R07]
      end else if (portWr && portWrIdx != 3'h7 && seq_q == ST_RUN) begin
         portLatch_q[portWrIdx] <= portWrData;
         if (portWrIdx == 3'h0) begin
            port0Oe_q <= ~portWrData;
         end
      end
   end

   // input-only ports: no latch, the pins are read every cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         port7Read_q <= 8'h00;
         port8Read_q <= 8'h00;
      end else begin
         port7Read_q <= port7Pins;  // [R08]
         port8Read_q <= port8Pins;  // [R08]
      end
   end

   // power-down modes; external reset wins over the hardware input
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hwPowerDown_q <= 1'b0;
         swPowerDown_q <= 1'b0;
      end else begin
         hwPowerDown_q <= hw_powerdown_input && !extRst;  // [R19]
         if (extRst) begin
            swPowerDown_q <= 1'b0;  // [R20]
         end else if (swPowerdownReq && seq_q == ST_RUN) begin
            swPowerDown_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         reset_out_n <= 1'b0;
         cpuRun_q    <= 1'b0;
         clkFromRc   <= 1'b1;
      end else begin
         reset_out_n <= !rstAll;  // [R23]
         cpuRun_q    <= seq_d == ST_RUN;  // [R18]
         clkFromRc   <= useRc;  // [R16]
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   strobeInputs_a : assert property (rstAll  // [R03]
      |=> !strobe_q.aleOe && !strobe_q.progStoreOe)
      else $error("strobe driven during reset");
   sampleOnce_a : assert property ($changed(lowCnt_q)  // [R10]
      |-> $past(tick) && $past(phase_q) == `PH_S5P2)
      else $error("reset pin sampled outside S5P2");
   secondLow_a : assert property (lowCnt_q == `LOW_MC_ACT  // [R02] [R18]
      |=> !reset_out_n ##1 !cpuRun_q)
      else $error("internal reset missing after two low samples");
   startAddr_a : assert property ($rose(fetch_q.valid)  // [R05]
      |-> fetch_q.addr == `BOOT_ADDR && strobe_q.aleOut && phase_q == `PH_S5P2)
      else $error("first fetch not at address zero in S5P1");
   aleFall_a : assert property ($fell(strobe_q.aleOut) && !$past(rstAll)  // [R13]
      |-> phase_q == `PH_AFTER_S5P2 && cpuRun_q)
      else $error("first strobe fall not at S5P2");
   portsOnes_a : assert property (sfrLoad_q  // [R07]
      |-> portLatch_q == {7{`PORT_RST_VAL}} && port0Oe_q == 8'h00)
      else $error("port latches not ones after reset");
   livePins_a : assert property (##1 port7Read_q == $past(port7Pins)  // [R08]
      && port8Read_q == $past(port8Pins))
      else $error("input port read does not follow pins");
   hwPdOverride_a : assert property (extRst  // [R19]
      |=> !hwPowerDown_q && !swPowerDown_q)
      else $error("power-down survives external reset");
   minReset_a : assert property ($rose(intMc_q != 2'h0)  // [R23]
      |-> rstAll [*2])
      else $error("internal reset shorter than two cycles");

   releaseRun_c : cover property ($fell(strobe_q.aleOut) ##1 cpuRun_q);
   bootstrap_c  : cover property ($rose(cpuRun_q) && bootstrapMode_q);
   extHold_c    : cover property (!owdRst && extRst ##1 extRst);
endmodule

// *** shared/reset_seq_defs.svh ***
// timing, position and reset-value constants of the reset sequencer
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH
`define PH_PER_MC     4'hC
`define PH_LAST       4'hB
`define PH_S5P1       4'h8
`define PH_S5P2       4'h9
`define PH_AFTER_S5P2 4'hA
`define LOW_MC_ACT    2'h2
`define RST_MIN_MC    2'h2
`define PORT_RST_VAL  8'hFF
`define BOOT_ADDR     16'h0000
`define OWD_HOLD_RC   10'h300
`define OWD_WIN_RC    4'h8
`endif

// *** shared/reset_seq_pkg.sv ***
// types shared by the reset sequencer files
package reset_seq_pkg;
   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_RESET = 2'b01,
      ST_WAIT  = 2'b10,
      ST_ALE   = 2'b11
   } seq_t;

   typedef struct packed {
      logic aleOut;
      logic aleOe;
      logic progStoreOut;
      logic progStoreOe;
   } strobe_t;

   typedef struct packed {
      logic        valid;
      logic        extMem;
      logic [15:0] addr;
   } fetch_t;
endpackage

// *** logic/osc_watchdog.sv ***
// oscillator watchdog: failure detect, clock select, hold-off reset, status flag
`timescale 1ns/1ps
`include "reset_seq_defs.svh"
module osc_watchdog (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // oscillator ticks
   input  wire logic oscTick,
   input  wire logic rcTick,
   // external reset seen by the sequencer
   input  wire logic extRstActive,
   // results
   output logic      useRc_q,
   output logic      owdRstReq_q,
   output logic      owdStatus_q
);
   logic [3:0] winCnt_q;
   logic [4:0] oscCnt_q;
   logic       fail_q;
   logic [9:0] holdCnt_q;
   logic       winEnd;

   assign winEnd = rcTick && (winCnt_q == `OWD_WIN_RC - 4'h1);

   // count main ticks across a window of rc ticks
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         winCnt_q <= 4'h0;
         oscCnt_q <= 5'h00;
      end else begin
         if (rcTick) begin
            winCnt_q <= winEnd ? 4'h0 : winCnt_q + 4'h1;
         end
         if (winEnd) begin
            oscCnt_q <= {4'h0, oscTick};
         end else if (oscTick && oscCnt_q != 5'h1F) begin
            oscCnt_q <= oscCnt_q + 5'h01;
         end
      end
   end

   // failed while the rc oscillator outruns the main one, also from power-on
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fail_q <= 1'b1;  // [R15]
      end else if (winEnd) begin
         fail_q <= oscCnt_q < {1'b0, `OWD_WIN_RC};  // [R15]
      end
   end

   // hold reset for the stabilising interval, then hand the clock back
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         useRc_q     <= 1'b1;
         owdRstReq_q <= 1'b1;
         holdCnt_q   <= 10'h000;
      end else if (fail_q) begin
         useRc_q     <= 1'b1;  // [R16]
         owdRstReq_q <= 1'b1;
         holdCnt_q   <= 10'h000;
      end else if (owdRstReq_q && rcTick) begin
         if (holdCnt_q == `OWD_HOLD_RC - 10'h001) begin
            useRc_q     <= 1'b0;  // [R17]
            owdRstReq_q <= 1'b0;
         end else begin
            holdCnt_q <= holdCnt_q + 10'h001;
         end
      end
   end

   // status flag: set by a failure, cleared by external reset, set wins
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         owdStatus_q <= 1'b1;
      end else if (fail_q) begin
         owdStatus_q <= 1'b1;
      end else if (extRstActive) begin
         owdStatus_q <= 1'b0;  // [R21]
      end
   end

   holdAtRelease_a : assert property (@(posedge clk_sys) disable iff (!nrst)  // [R17]
      $fell(owdRstReq_q) |-> $past(holdCnt_q) == 10'h2FF && !useRc_q)
      else $error("watchdog released before the hold count");
   rcClockRst_a : assert property (@(posedge clk_sys) disable iff (!nrst)  // [R16]
      fail_q |=> useRc_q && owdRstReq_q)
      else $error("failure without rc clock and reset");
   statusClear_a : assert property (@(posedge clk_sys) disable iff (!nrst)  // [R21]
      extRstActive && !fail_q |=> !owdStatus_q)
      else $error("status flag not cleared by external reset");
   holdDone_c : cover property (@(posedge clk_sys) disable iff (!nrst) $fell(owdRstReq_q));
endmodule

// *** bench/reset_supervisor_model.sv ***
// reset supervisor on the board side: drives the active-low reset pin
`timescale 1ns/1ps
module reset_supervisor_model (
   // clock and main oscillator tick
   input  wire logic clk_sys,
   input  wire logic oscTick,
   // reset pin
   output logic      resetInN
);
   import reset_seq_pkg::*;

   // power-on: the capacitor holds the pin low until the bench lets it go
   initial resetInN = 1'b0;

   // the model has no driver on the strobe pins, so they are never stimulated in reset

   // pull low and hold for a number of oscillator periods; longer holds model a slow supervisor
   task automatic hold_low(input int periods);
      int n = 0;
      @(posedge clk_sys);
      #1 resetInN = 1'b0;
      while (n < periods) begin
         @(posedge clk_sys);
         if (oscTick) n++;
      end
   endtask

   // release: the internal pull-up takes the pin high
   task automatic release_pin();
      @(posedge clk_sys);
      #1 resetInN = 1'b1;
   endtask
endmodule

// *** bench/reset_sync_and_power_on_sequencer_test.sv ***
// self-checking bench of the reset synchroniser and power-on sequencer
`timescale 1ns/1ps
`include "reset_seq_defs.svh"
module reset_sync_and_power_on_sequencer_test;
   import reset_seq_pkg::*;
   localparam int TIMEOUT = 20000;
   logic            clk_sys = 1'b0;
   logic            nrst = 1'b0;
   logic            oscTick = 1'b0;
   logic            rcTick = 1'b0;
   logic            oscOn = 1'b0;
   logic [2:0]      tickCnt = 3'h0;
   wire logic       resetInN;
   logic            boot_select_pin = 1'b0;
   logic            hw_powerdown_input = 1'b0;
   logic [7:0]      port7Pins = 8'h00;
   logic [7:0]      port8Pins = 8'h00;
   logic            wdtRstReq = 1'b0;
   logic            swPowerdownReq = 1'b0;
   logic            portWr = 1'b0;
   logic [2:0]      portWrIdx = 3'h0;
   logic [7:0]      portWrData = 8'h00;
   strobe_t         strobe_q;
   fetch_t          fetch_q;
   logic [6:0][7:0] portLatch_q;
   logic [7:0]      port0Oe_q, port7Read_q, port8Read_q;
   logic            reset_out_n, bootstrapMode_q, sfrLoad_q, cpuRun_q;
   logic            swPowerDown_q, hwPowerDown_q, osc_fail_status_flag, clkFromRc;
   logic [16:0]     fetchQ[$];
   logic [16:0]     expFetch;
   logic            validPrev = 1'b0, alePrev = 1'b0, measuring = 1'b0;
   int              relTicks = 0, cycles = 0, bad_count = 0, check_count = 0;
   int unsigned     rndSeed;

   always #4 clk_sys = ~clk_sys;

   // main oscillator tick every second clock once started, rc tick every fourth
   always @(posedge clk_sys) begin
      tickCnt <= tickCnt + 3'h1;
      oscTick <= #1 oscOn & tickCnt[0];
      rcTick  <= #1 (tickCnt[1:0] == 2'h3);
   end

   reset_supervisor_model sup (.clk_sys(clk_sys), .oscTick(oscTick), .resetInN(resetInN));

   reset_sequencer dut (
      .clk_sys(clk_sys), .nrst(nrst), .oscTick(oscTick), .rcTick(rcTick),
      .resetInN(resetInN), .boot_select_pin(boot_select_pin),
      .hw_powerdown_input(hw_powerdown_input), .port7Pins(port7Pins), .port8Pins(port8Pins),
      .wdtRstReq(wdtRstReq), .swPowerdownReq(swPowerdownReq), .portWr(portWr),
      .portWrIdx(portWrIdx), .portWrData(portWrData), .strobe_q(strobe_q), .fetch_q(fetch_q),
      .portLatch_q(portLatch_q), .port0Oe_q(port0Oe_q), .port7Read_q(port7Read_q),
      .port8Read_q(port8Read_q), .reset_out_n(reset_out_n), .bootstrapMode_q(bootstrapMode_q),
      .sfrLoad_q(sfrLoad_q), .cpuRun_q(cpuRun_q), .swPowerDown_q(swPowerDown_q),
      .hwPowerDown_q(hwPowerDown_q), .osc_fail_status_flag(osc_fail_status_flag),
      .clkFromRc(clkFromRc));

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return reset_out_n;
         1: return cpuRun_q;
         default: return clkFromRc;
      endcase
   endfunction

   // bounded wait for a level on reset output, run or clock select
   task automatic wait_for(input string what, input int sel, input logic lvl, input int limit);
      int n = 0;
      while (pick(sel) !== lvl && n < limit) begin
         @(posedge clk_sys);
         #2 n++;
      end
      check(what, {17'h0, lvl}, {17'h0, pick(sel)});
   endtask

   task automatic port_reads(input int n);
      logic [15:0] v;
      repeat (n) begin
         @(posedge clk_sys);
         v = 16'($urandom);
         #1 {port7Pins, port8Pins} = v;
         settle(1);
         check("port 7 and 8 read", {2'h0, v}, {2'h0, port7Read_q, port8Read_q});
      end
   endtask

   task automatic in_reset_checks();
      check("reset output", 18'h0, {17'h0, reset_out_n});
      check("cpu run", 18'h0, {17'h0, cpuRun_q});
      check("strobe oe", 18'h0, {16'h0, strobe_q.aleOe, strobe_q.progStoreOe});
      check("register load", 18'h1, {17'h0, sfrLoad_q});
      check("port0 pull-low", 18'h0, {10'h0, port0Oe_q});
      for (int k = 0; k < 7; k++)
         check("port latch", {10'h0, `PORT_RST_VAL}, {10'h0, portLatch_q[k]});
   endtask

   task automatic release_reset(input logic boot);
      fetchQ.push_back({~boot, `BOOT_ADDR});
      sup.release_pin();
      relTicks = 0;
      measuring = 1'b1;
      wait_for("run after release", 1, 1'b1, 400);
      check("boot mode", {17'h0, boot}, {17'h0, bootstrapMode_q});
      check("strobe oe", 18'h7,
            {15'h0, strobe_q.progStoreOut, strobe_q.aleOe, strobe_q.progStoreOe});
   endtask

   task automatic pulse_wr(input logic [2:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      #1 portWr = 1'b1;
      portWrIdx = idx;
      portWrData = d;
      swPowerdownReq = 1'b1;
      @(posedge clk_sys);
      #1 portWr = 1'b0;
      swPowerdownReq = 1'b0;
      settle(2);
      check("port latch write", {10'h0, d}, {10'h0, portLatch_q[idx]});
      check("port0 pull-low", {10'h0, (idx == 3'h0) ? ~d : 8'h00}, {10'h0, port0Oe_q});
      check("software power-down", 18'h1, {17'h0, swPowerDown_q});
   endtask

   // watcher: first fetch against the oldest note, strobe fall against the release
   always @(posedge clk_sys) begin
      cycles++;
      if (oscTick)
         relTicks++;
      validPrev <= fetch_q.valid;
      alePrev   <= strobe_q.aleOut;
      if (fetch_q.valid === 1'b1 && validPrev !== 1'b1) begin
         expFetch = (fetchQ.size() > 0) ? fetchQ.pop_front() : 17'h1FFFF;
         check("first fetch", {1'b0, expFetch}, {1'b0, fetch_q.extMem, fetch_q.addr});
      end
      if (measuring && alePrev === 1'b1 && strobe_q.aleOut === 1'b0) begin
         measuring = 1'b0;
         check("release to strobe fall", 18'h1, {17'h0, relTicks >= 12 && relTicks <= 24});
      end
      if (cycles >= TIMEOUT) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      rndSeed = $urandom(32'h69dcfd6e);
      repeat (10) @(posedge clk_sys);
      #1 nrst = 1'b1;
      // power-on with the main oscillator still absent
      settle(200);
      check("failure flag", 18'h1, {17'h0, osc_fail_status_flag});
      check("clock from rc", 18'h1, {17'h0, clkFromRc});
      hw_powerdown_input = 1'b1;
      port_reads(3);
      in_reset_checks();
      check("hardware power-down", 18'h0, {17'h0, hwPowerDown_q});
      hw_powerdown_input = 1'b0;
      oscOn = 1'b1;
      // supervisor keeps reset through the watchdog hold-off
      wait_for("clock back to main", 2, 1'b0, 3400);
      settle(80);
      check("failure flag cleared", 18'h0, {17'h0, osc_fail_status_flag});
      in_reset_checks();
      boot_select_pin = 1'($urandom);
      release_reset(boot_select_pin);
      // prompt then slow external reset, each boot mode
      for (int i = 0; i < 2; i++) begin
         pulse_wr(3'($urandom % 7), 8'($urandom));
         sup.hold_low(24 + 40 * i);
         sup.hold_low(30);
         settle(1);
         in_reset_checks();
         check("software power-down", 18'h0, {17'h0, swPowerDown_q});
         boot_select_pin = 1'(i);
         release_reset(1'(i));
      end
      // hardware power-down follows its input while no external reset is seen
      @(posedge clk_sys);
      #1 hw_powerdown_input = 1'b1;
      settle(2);
      check("hardware power-down", 18'h1, {17'h0, hwPowerDown_q});
      @(posedge clk_sys);
      #1 hw_powerdown_input = 1'b0;
      // a low shorter than one machine cycle meets at most one sample
      sup.hold_low(6);
      sup.release_pin();
      settle(60);
      check("short low ignored", 18'h1, {17'h0, reset_out_n & cpuRun_q});
      // watchdog-timer request is stretched to two machine cycles
      fetchQ.push_back({~boot_select_pin, `BOOT_ADDR});
      @(posedge clk_sys);
      #1 wdtRstReq = 1'b1;
      @(posedge clk_sys);
      #1 wdtRstReq = 1'b0;
      wait_for("watchdog reset output", 0, 1'b0, 60);
      relTicks = 0;
      wait_for("watchdog reset over", 0, 1'b1, 400);
      check("internal reset length", 18'h1, {17'h0, relTicks >= 24});
      wait_for("run after watchdog reset", 1, 1'b1, 400);
      port_reads(4);
      check("fetch notes left", 18'h0, 18'(fetchQ.size()));
      end_of_test();
   end
endmodule
